// ===== logic/ccu_pkg.sv
// constants and helpers of the capture unit
package ccu_pkg;

    localparam int CCU_NUM_UNITS = 5;
    localparam int CCU_AW = 4;
    localparam int CCU_DW = 8;
    localparam int CCU_TW = 16;
    localparam int CCU_MODE_W = 4;
    localparam int CCU_SRC_W = 3;
    localparam int CCU_PRESC_W = 4;

    // register offsets
    localparam logic [CCU_AW-1:0] CCU_OFF_CONTROL = 4'h0;
    localparam logic [CCU_AW-1:0] CCU_OFF_SOURCE = 4'h1;
    localparam logic [CCU_AW-1:0] CCU_OFF_VALUE_LOW = 4'h2;
    localparam logic [CCU_AW-1:0] CCU_OFF_VALUE_HIGH = 4'h3;
    localparam logic [CCU_AW-1:0] CCU_OFF_STATUS = 4'h4;
    localparam logic [CCU_AW-1:0] CCU_OFF_MASK = 4'h5;

    // field positions
    localparam int CCU_CTL_EN_BIT = 7;
    localparam int CCU_FLAG_BIT = 0;

    // reset values
    localparam logic [CCU_MODE_W-1:0] CCU_MODE_RESET = 4'h0;
    localparam logic [CCU_SRC_W-1:0] CCU_SRC_RESET = 3'h0;
    localparam logic [CCU_TW-1:0] CCU_VALUE_RESET = 16'h0000;
    localparam logic [CCU_DW-1:0] CCU_RDATA_RESET = 8'h00;
    localparam logic [CCU_PRESC_W-1:0] CCU_PRESC_RESET = 4'h0;

    // capture mode codes
    localparam logic [CCU_MODE_W-1:0] CCU_MODE_FALL = 4'h4;
    localparam logic [CCU_MODE_W-1:0] CCU_MODE_RISE = 4'h5;
    localparam logic [CCU_MODE_W-1:0] CCU_MODE_RISE4 = 4'h6;
    localparam logic [CCU_MODE_W-1:0] CCU_MODE_RISE16 = 4'h7;
    localparam logic [CCU_MODE_W-1:0] CCU_CAP_MASK = 4'hc;
    localparam logic [CCU_MODE_W-1:0] CCU_CAP_MATCH = 4'h4;

    // prescaler terminal counts
    localparam logic [1:0] CCU_PRESC_LAST4 = 2'h3;
    localparam logic [CCU_PRESC_W-1:0] CCU_PRESC_LAST16 = 4'hf;
    localparam logic [CCU_PRESC_W-1:0] CCU_PRESC_STEP = 4'h1;

    // source select codes
    localparam logic [CCU_SRC_W-1:0] CCU_SRC_PIN = 3'h0;
    localparam logic [CCU_SRC_W-1:0] CCU_SRC_CMP1 = 3'h1;
    localparam logic [CCU_SRC_W-1:0] CCU_SRC_CMP2 = 3'h2;
    localparam logic [CCU_SRC_W-1:0] CCU_SRC_PCHG = 3'h3;
    localparam logic [CCU_SRC_W-1:0] CCU_SRC_LC1 = 3'h4;
    localparam logic [CCU_SRC_W-1:0] CCU_SRC_LC2 = 3'h5;
    localparam logic [CCU_SRC_W-1:0] CCU_SRC_LC3 = 3'h6;
    localparam logic [CCU_SRC_W-1:0] CCU_SRC_LC4 = 3'h7;

    function automatic logic ccu_is_capture(input logic [CCU_MODE_W-1:0] mode);
        return (mode & CCU_CAP_MASK) == CCU_CAP_MATCH;
    endfunction

endpackage

// ===== logic/ccu_sync3.sv
// three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
module ccu_sync3 (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // level in and out
    input wire logic din,
    output logic dout
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } ccu_sync_s;

    ccu_sync_s sync_reg;
    ccu_sync_s sync_next;

    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = din;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        // stage one is metastable-prone, so only the later two vote
        if (sync_reg.s2 == sync_reg.s3) begin
            sync_next.out = sync_reg.s3;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg.out;

endmodule

// ===== logic/ccu_edge_presc.sv
// edge qualifier and capture prescaler
`timescale 1ns/1ps
module ccu_edge_presc (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // configuration
    input wire logic enable,
    input wire logic [ccu_pkg::CCU_MODE_W-1:0] mode,
    // selected source level
    input wire logic src_level,
    // one-cycle qualifying event
    output logic hit
);

    typedef struct packed {
        logic prev;
        logic [ccu_pkg::CCU_PRESC_W-1:0] cnt;
        logic hit;
    } ccu_edge_s;

    ccu_edge_s edge_reg;
    ccu_edge_s edge_next;
    logic rise;
    logic fall;
    logic active;

    assign rise = src_level && !edge_reg.prev;
    assign fall = !src_level && edge_reg.prev;
    assign active = enable && ccu_pkg::ccu_is_capture(mode);

    always_comb begin
        edge_next = edge_reg;
        edge_next.prev = src_level;
        edge_next.hit = 1'b0;
        if (!active) begin
            edge_next.cnt = ccu_pkg::CCU_PRESC_RESET;
        end else begin
            // count is not cleared on a prescale change: software must disable first
            if (rise) begin
                edge_next.cnt = edge_reg.cnt + ccu_pkg::CCU_PRESC_STEP;
            end
            unique case (mode)
                ccu_pkg::CCU_MODE_FALL: edge_next.hit = fall;
                ccu_pkg::CCU_MODE_RISE: edge_next.hit = rise;
                ccu_pkg::CCU_MODE_RISE4: begin
                    edge_next.hit = rise && edge_reg.cnt[1:0] == ccu_pkg::CCU_PRESC_LAST4;
                end
                ccu_pkg::CCU_MODE_RISE16: begin
                    edge_next.hit = rise && edge_reg.cnt == ccu_pkg::CCU_PRESC_LAST16;
                end
                default: edge_next.hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            edge_reg <= '0;
        end else begin
            edge_reg <= edge_next;
        end
    end

    assign hit = edge_reg.hit;

    ////////////////////////////////////////////////////////////////////////////
    property p_presc_clear;
        @(posedge clock) disable iff (!nrst)
        !active |=> edge_reg.cnt == ccu_pkg::CCU_PRESC_RESET;
    endproperty
    a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

    property p_fall_hit;
        @(posedge clock) disable iff (!nrst)
        active && mode == ccu_pkg::CCU_MODE_FALL && fall |=> hit;
    endproperty
    a_fall_hit: assert property (p_fall_hit) else $error("falling edge missed");

    property p_rise16_only;
        @(posedge clock) disable iff (!nrst)
        active && mode == ccu_pkg::CCU_MODE_RISE16 && rise
            && edge_reg.cnt != ccu_pkg::CCU_PRESC_LAST16 |=> !hit;
    endproperty
    a_rise16_only: assert property (p_rise16_only) else $error("early 16th capture");

    property p_presc_hold;
        @(posedge clock) disable iff (!nrst)
        active && !rise && $past(active) |=> $stable(edge_reg.cnt);
    endproperty
    a_presc_hold: assert property (p_presc_hold) else $error("prescaler moved");

    c_rise4: cover property (@(posedge clock) disable iff (!nrst)
        mode == ccu_pkg::CCU_MODE_RISE4 && hit);

endmodule

// ===== logic/ccu_capture_unit.sv
// capture unit top: register port, source select, capture and interrupt
`timescale 1ns/1ps
module ccu_capture_unit (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire logic [ccu_pkg::CCU_AW-1:0] reg_addr,
    input wire logic [ccu_pkg::CCU_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ccu_pkg::CCU_DW-1:0] reg_rdata,
    // timer count
    input wire logic [ccu_pkg::CCU_DW-1:0] timer_count_high,
    input wire logic [ccu_pkg::CCU_DW-1:0] timer_count_low,
    // capture pin
    input wire logic mapped_capture_pin,
    input wire logic pin_direction_control,
    input wire logic port_latch_level,
    // internal event sources
    input wire logic comparator_one_synced,
    input wire logic comparator_two_synced,
    input wire logic pin_change_event,
    input wire logic logic_cell_one_output,
    input wire logic logic_cell_two_output,
    input wire logic logic_cell_three_output,
    input wire logic logic_cell_four_output,
    // power state
    input wire logic sleep_active,
    input wire logic timer_ext_clocked,
    // events out
    output logic capture_pulse,
    output logic capture_irq
);

    // each of the five instances keeps its own copy of this register set
    typedef struct packed {
        logic en;
        logic [ccu_pkg::CCU_MODE_W-1:0] mode;
        logic [ccu_pkg::CCU_SRC_W-1:0] src_sel;
        logic [ccu_pkg::CCU_TW-1:0] value;
        logic flag;
        logic mask;
        logic [ccu_pkg::CCU_DW-1:0] rdata;
        logic pulse;
        logic irq;
    } ccu_main_s;

    ccu_main_s main_reg;
    ccu_main_s main_next;
    logic pin_synced;
    logic pin_level;
    logic [7:0] src_vec;
    logic selected;
    logic hit;
    logic hit_go;
    logic flag_clear;

    ////////////////////////////////////////////////////////////////////////////
    // sources

    ccu_sync3 u_pin_sync (
        .clock(clock),
        .nrst(nrst),
        .din(mapped_capture_pin),
        .dout(pin_synced)
    );

    // an output pin reflects the port latch, so a port write can capture
    assign pin_level = pin_direction_control ? pin_synced : port_latch_level;

    always_comb begin
        src_vec = '0;
        src_vec[ccu_pkg::CCU_SRC_PIN] = pin_level;
        src_vec[ccu_pkg::CCU_SRC_CMP1] = comparator_one_synced;
        src_vec[ccu_pkg::CCU_SRC_CMP2] = comparator_two_synced;
        src_vec[ccu_pkg::CCU_SRC_PCHG] = pin_change_event;
        src_vec[ccu_pkg::CCU_SRC_LC1] = logic_cell_one_output;
        src_vec[ccu_pkg::CCU_SRC_LC2] = logic_cell_two_output;
        src_vec[ccu_pkg::CCU_SRC_LC3] = logic_cell_three_output;
        src_vec[ccu_pkg::CCU_SRC_LC4] = logic_cell_four_output;
    end

    assign selected = src_vec[main_reg.src_sel];

    // mode changes pass straight through, so a stale edge may flag once
    ccu_edge_presc u_edge (
        .clock(clock),
        .nrst(nrst),
        .enable(main_reg.en),
        .mode(main_reg.mode),
        .src_level(selected),
        .hit(hit)
    );

    // a timer on the instruction clock is frozen in sleep
    assign hit_go = hit && (!sleep_active || timer_ext_clocked);

    ////////////////////////////////////////////////////////////////////////////
    // register read decode

    function automatic logic [ccu_pkg::CCU_DW-1:0] read_word(
        input logic [ccu_pkg::CCU_AW-1:0] addr,
        input ccu_main_s st
    );
        logic [ccu_pkg::CCU_DW-1:0] w;
        w = '0;
        unique case (addr)
            ccu_pkg::CCU_OFF_CONTROL: begin
                w[ccu_pkg::CCU_CTL_EN_BIT] = st.en;
                w[ccu_pkg::CCU_MODE_W-1:0] = st.mode;
            end
            ccu_pkg::CCU_OFF_SOURCE: w[ccu_pkg::CCU_SRC_W-1:0] = st.src_sel;
            ccu_pkg::CCU_OFF_VALUE_LOW: w = st.value[ccu_pkg::CCU_DW-1:0];
            ccu_pkg::CCU_OFF_VALUE_HIGH: w = st.value[ccu_pkg::CCU_TW-1:ccu_pkg::CCU_DW];
            ccu_pkg::CCU_OFF_STATUS: w[ccu_pkg::CCU_FLAG_BIT] = st.flag;
            ccu_pkg::CCU_OFF_MASK: w[ccu_pkg::CCU_FLAG_BIT] = st.mask;
            default: w = '0;
        endcase
        return w;
    endfunction

    assign flag_clear = reg_wr && reg_addr == ccu_pkg::CCU_OFF_STATUS
        && reg_wdata[ccu_pkg::CCU_FLAG_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        main_next = main_reg;
        main_next.rdata = ccu_pkg::CCU_RDATA_RESET;
        if (reg_wr) begin
            unique case (reg_addr)
                ccu_pkg::CCU_OFF_CONTROL: begin
                    main_next.en = reg_wdata[ccu_pkg::CCU_CTL_EN_BIT];
                    main_next.mode = reg_wdata[ccu_pkg::CCU_MODE_W-1:0];
                end
                ccu_pkg::CCU_OFF_SOURCE: begin
                    main_next.src_sel = reg_wdata[ccu_pkg::CCU_SRC_W-1:0];
                end
                ccu_pkg::CCU_OFF_VALUE_LOW: begin
                    main_next.value[ccu_pkg::CCU_DW-1:0] = reg_wdata;
                end
                ccu_pkg::CCU_OFF_VALUE_HIGH: begin
                    main_next.value[ccu_pkg::CCU_TW-1:ccu_pkg::CCU_DW] = reg_wdata;
                end
                ccu_pkg::CCU_OFF_MASK: begin
                    main_next.mask = reg_wdata[ccu_pkg::CCU_FLAG_BIT];
                end
                default: main_next.mask = main_reg.mask;
            endcase
        end
        if (flag_clear) begin
            main_next.flag = 1'b0;
        end
        // capture after the writes: a same-cycle event beats both clear and value write
        if (hit_go) begin
            main_next.value = {timer_count_high, timer_count_low};
            main_next.flag = 1'b1;
        end
        if (reg_rd) begin
            main_next.rdata = read_word(reg_addr, main_reg);
        end
        main_next.pulse = hit_go;
        main_next.irq = main_next.flag && main_next.mask;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            main_reg.en <= 1'b0;
            main_reg.mode <= ccu_pkg::CCU_MODE_RESET;
            main_reg.src_sel <= ccu_pkg::CCU_SRC_RESET;
            main_reg.value <= ccu_pkg::CCU_VALUE_RESET;
            main_reg.flag <= 1'b0;
            main_reg.mask <= 1'b0;
            main_reg.rdata <= ccu_pkg::CCU_RDATA_RESET;
            main_reg.pulse <= 1'b0;
            main_reg.irq <= 1'b0;
        end else begin
            main_reg <= main_next;
        end
    end

    assign reg_rdata = main_reg.rdata;
    assign capture_pulse = main_reg.pulse;
    assign capture_irq = main_reg.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_capture_copy;
        @(posedge clock) disable iff (!nrst)
        hit_go |=> main_reg.value == $past({timer_count_high, timer_count_low});
    endproperty
    a_capture_copy: assert property (p_capture_copy) else $error("count not captured");

    property p_flag_set;
        @(posedge clock) disable iff (!nrst)
        hit_go |=> main_reg.flag ##1 (main_reg.flag || $past(flag_clear));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_flag_sticky;
        @(posedge clock) disable iff (!nrst)
        main_reg.flag && !flag_clear |=> main_reg.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_overwrite;
        @(posedge clock) disable iff (!nrst)
        main_reg.flag && hit_go |=> main_reg.value == $past({timer_count_high, timer_count_low});
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("old value kept");

    property p_port_write;
        @(posedge clock) disable iff (!nrst)
        !pin_direction_control && main_reg.src_sel == ccu_pkg::CCU_SRC_PIN
            |-> selected == port_latch_level;
    endproperty
    a_port_write: assert property (p_port_write) else $error("port latch not used");

    property p_src_pchg;
        @(posedge clock) disable iff (!nrst)
        main_reg.src_sel == ccu_pkg::CCU_SRC_PCHG |-> selected == pin_change_event;
    endproperty
    a_src_pchg: assert property (p_src_pchg) else $error("wrong source");

    property p_sleep_hold;
        @(posedge clock) disable iff (!nrst)
        sleep_active && !timer_ext_clocked && !(reg_wr && reg_addr != ccu_pkg::CCU_OFF_STATUS)
            |=> $stable(main_reg.value) && !capture_pulse;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("capture in sleep");

    property p_irq;
        @(posedge clock) disable iff (!nrst)
        main_reg.flag && main_reg.mask |-> capture_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_rdata_idle;
        @(posedge clock) disable iff (!nrst)
        !reg_rd |=> reg_rdata == ccu_pkg::CCU_RDATA_RESET;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data stands");

    property p_capture_off;
        @(posedge clock) disable iff (!nrst)
        !(main_reg.en && ccu_pkg::ccu_is_capture(main_reg.mode)) |=> !hit;
    endproperty
    a_capture_off: assert property (p_capture_off) else $error("event while off");

    property p_pulse_flag;
        @(posedge clock) disable iff (!nrst)
        capture_pulse |-> main_reg.flag;
    endproperty
    a_pulse_flag: assert property (p_pulse_flag) else $error("pulse without flag");

    property p_flag_clear;
        @(posedge clock) disable iff (!nrst)
        flag_clear && !hit_go |=> !main_reg.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_set_wins;
        @(posedge clock) disable iff (!nrst)
        flag_clear && hit_go |=> main_reg.flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat capture");

    property p_read_low;
        @(posedge clock) disable iff (!nrst)
        reg_rd && reg_addr == ccu_pkg::CCU_OFF_VALUE_LOW
            |=> reg_rdata == $past(main_reg.value[ccu_pkg::CCU_DW-1:0]);
    endproperty
    a_read_low: assert property (p_read_low) else $error("low byte read wrong");

    property p_read_high;
        @(posedge clock) disable iff (!nrst)
        reg_rd && reg_addr == ccu_pkg::CCU_OFF_VALUE_HIGH
            |=> reg_rdata == $past(main_reg.value[ccu_pkg::CCU_TW-1:ccu_pkg::CCU_DW]);
    endproperty
    a_read_high: assert property (p_read_high) else $error("high byte read wrong");

    property p_read_status;
        @(posedge clock) disable iff (!nrst)
        reg_rd && reg_addr == ccu_pkg::CCU_OFF_STATUS
            |=> reg_rdata[ccu_pkg::CCU_FLAG_BIT] == $past(main_reg.flag);
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong");

    property p_src_pin;
        @(posedge clock) disable iff (!nrst)
        pin_direction_control && main_reg.src_sel == ccu_pkg::CCU_SRC_PIN
            |-> selected == pin_synced;
    endproperty
    a_src_pin: assert property (p_src_pin) else $error("pin source wrong");

    property p_ctrl_write;
        @(posedge clock) disable iff (!nrst)
        reg_wr && reg_addr == ccu_pkg::CCU_OFF_CONTROL
            |=> main_reg.mode == $past(reg_wdata[ccu_pkg::CCU_MODE_W-1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("mode not written");

    c_capture: cover property (@(posedge clock) disable iff (!nrst) hit_go);
    c_overwrite: cover property (@(posedge clock) disable iff (!nrst) main_reg.flag && hit_go);
    c_irq: cover property (@(posedge clock) disable iff (!nrst) capture_irq ##1 !capture_irq);
    c_fall: cover property (@(posedge clock) disable iff (!nrst)
        hit_go && main_reg.mode == ccu_pkg::CCU_MODE_FALL);

endmodule

// ===== bench/ccu_far_model.sv
// far-side model: timer that feeds the capture unit
`timescale 1ns/1ps
module ccu_far_model #(
    parameter logic [15:0] STEP = 16'h0103
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // sleep freeze
    input wire logic hold,
    // timer count
    output logic [7:0] timer_count_high,
    output logic [7:0] timer_count_low
);
    logic [15:0] count_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // counts on the unit's own clock, so every value is synchronous to it
    // odd step keeps both bytes moving
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 16'h0000;
        end else if (!hold) begin
            count_reg <= count_reg + STEP;
        end
    end

    assign timer_count_high = count_reg[15:8];
    assign timer_count_low = count_reg[7:0];
endmodule

// ===== bench/tb.sv
// self-checking bench of the capture unit
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] TSTEP = 16'h0103;
    logic clock;
    logic nrst;
    logic [ccu_pkg::CCU_AW-1:0] reg_addr;
    logic [ccu_pkg::CCU_DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [ccu_pkg::CCU_DW-1:0] reg_rdata;
    logic [7:0] timer_count_high;
    logic [7:0] timer_count_low;
    logic [8:0] src;
    logic pin_direction_control;
    logic sleep_active;
    logic timer_ext_clocked;
    logic capture_pulse;
    logic capture_irq;
    logic [7:0] rdata_seen;
    logic [15:0] exp_val;
    logic [15:0] held;
    int npulse;
    int num_errors;
    int total_checks;

    ccu_far_model #(.STEP(TSTEP)) u_far (
        .clock(clock),
        .nrst(nrst),
        .hold(sleep_active & ~timer_ext_clocked),
        .timer_count_high(timer_count_high),
        .timer_count_low(timer_count_low)
    );

    ccu_capture_unit u_dut (
        .clock(clock),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .timer_count_high(timer_count_high),
        .timer_count_low(timer_count_low),
        .mapped_capture_pin(src[0]),
        .pin_direction_control(pin_direction_control),
        .port_latch_level(src[8]),
        .comparator_one_synced(src[1]),
        .comparator_two_synced(src[2]),
        .pin_change_event(src[3]),
        .logic_cell_one_output(src[4]),
        .logic_cell_two_output(src[5]),
        .logic_cell_three_output(src[6]),
        .logic_cell_four_output(src[7]),
        .sleep_active(sleep_active),
        .timer_ext_clocked(timer_ext_clocked),
        .capture_pulse(capture_pulse),
        .capture_irq(capture_irq)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        rdata_seen = reg_rdata;
    endtask

    task automatic check_value();
        logic [15:0] got;
        reg_read(ccu_pkg::CCU_OFF_VALUE_LOW);
        got[7:0] = rdata_seen;
        reg_read(ccu_pkg::CCU_OFF_VALUE_HIGH);
        got[15:8] = rdata_seen;
        check("capture value", exp_val, got);
    endtask

    // ten cycles covers the pin synchroniser plus the capture path
    task automatic drive(input int idx, input logic lvl);
        @(posedge clock);
        src[idx] <= lvl;
        repeat (10) begin
            @(posedge clock);
            #1;
            if (capture_pulse === 1'b1) begin
                npulse++;
                exp_val = {timer_count_high, timer_count_low} - TSTEP;
            end
        end
    endtask

    task automatic toggle(input int idx, input int n);
        repeat (n) begin
            drive(idx, 1'b1);
            drive(idx, 1'b0);
        end
    endtask

    task automatic set_mode(input logic [3:0] mode);
        reg_write(ccu_pkg::CCU_OFF_MASK, 8'h00);
        reg_write(ccu_pkg::CCU_OFF_CONTROL, 8'h00);
        reg_write(ccu_pkg::CCU_OFF_CONTROL, {4'h8, mode});
        reg_write(ccu_pkg::CCU_OFF_STATUS, 8'h01);
        reg_write(ccu_pkg::CCU_OFF_MASK, 8'h01);
        npulse = 0;
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] pmode [2];
        int pcount [2];
        pmode[0] = ccu_pkg::CCU_MODE_RISE4;
        pmode[1] = ccu_pkg::CCU_MODE_RISE16;
        pcount[0] = 4;
        pcount[1] = 16;
        num_errors = 0;
        total_checks = 0;
        nrst = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        src = 9'h000;
        pin_direction_control = 1'b1;
        sleep_active = 1'b0;
        timer_ext_clocked = 1'b0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        // every register and one unmapped place read zero after reset
        for (int a = 0; a < 7; a++) begin
            reg_read((a == 6) ? 4'hf : a[3:0]);
            check("reset read", 16'h0000, {8'h00, rdata_seen});
        end
        reg_write(ccu_pkg::CCU_OFF_MASK, 8'h01);
        set_mode(ccu_pkg::CCU_MODE_RISE);
        for (int s = 0; s < 8; s++) begin
            reg_write(ccu_pkg::CCU_OFF_SOURCE, s[7:0]);
            npulse = 0;
            toggle(s, 1);
            check("source capture", 16'h1, npulse[15:0]);
            check_value();
            reg_read(ccu_pkg::CCU_OFF_STATUS);
            check("flag set", 16'h1, {8'h00, rdata_seen});
            check("irq", 16'h1, {15'h0, capture_irq});
            reg_write(ccu_pkg::CCU_OFF_STATUS, 8'h01);
            reg_read(ccu_pkg::CCU_OFF_STATUS);
            check("flag cleared", 16'h0, {8'h00, rdata_seen});
        end
        // unread value is overwritten by the later capture
        reg_write(ccu_pkg::CCU_OFF_SOURCE, 8'h01);
        npulse = 0;
        toggle(1, 2);
        check("two captures", 16'h2, npulse[15:0]);
        check_value();
        set_mode(ccu_pkg::CCU_MODE_FALL);
        drive(1, 1'b1);
        check("fall ignores rise", 16'h0, npulse[15:0]);
        drive(1, 1'b0);
        check("fall captures", 16'h1, npulse[15:0]);
        check_value();
        for (int m = 0; m < 2; m++) begin
            set_mode(pmode[m]);
            toggle(1, pcount[m] - 1);
            check("prescale early", 16'h0, npulse[15:0]);
            toggle(1, 1);
            check("prescale hit", 16'h1, npulse[15:0]);
            check_value();
        end
        // partial count must be lost on disable
        set_mode(ccu_pkg::CCU_MODE_RISE4);
        toggle(1, 2);
        set_mode(ccu_pkg::CCU_MODE_RISE4);
        toggle(1, 3);
        check("prescale cleared", 16'h0, npulse[15:0]);
        toggle(1, 1);
        check("prescale restart", 16'h1, npulse[15:0]);
        // enabled but outside capture mode also drops the count
        toggle(1, 2);
        reg_write(ccu_pkg::CCU_OFF_CONTROL, 8'h80);
        npulse = 0;
        toggle(1, 1);
        check("no capture mode", 16'h0, npulse[15:0]);
        reg_write(ccu_pkg::CCU_OFF_CONTROL, {4'h8, ccu_pkg::CCU_MODE_RISE4});
        toggle(1, 3);
        check("mode clears count", 16'h0, npulse[15:0]);
        // direct prescale switch keeps the three counted edges
        reg_write(ccu_pkg::CCU_OFF_CONTROL, {4'h8, ccu_pkg::CCU_MODE_RISE16});
        toggle(1, 12);
        check("switch keeps count", 16'h0, npulse[15:0]);
        toggle(1, 1);
        check("switch hit", 16'h1, npulse[15:0]);
        // pin as output: port latch change captures
        set_mode(ccu_pkg::CCU_MODE_RISE);
        reg_write(ccu_pkg::CCU_OFF_SOURCE, 8'h00);
        @(posedge clock);
        pin_direction_control <= 1'b0;
        toggle(8, 1);
        check("port write capture", 16'h1, npulse[15:0]);
        check_value();
        @(posedge clock);
        pin_direction_control <= 1'b1;
        reg_write(ccu_pkg::CCU_OFF_SOURCE, 8'h01);
        @(posedge clock);
        sleep_active <= 1'b1;
        npulse = 0;
        @(posedge clock);
        #1;
        held = {timer_count_high, timer_count_low};
        toggle(1, 1);
        check("sleep no capture", 16'h0, npulse[15:0]);
        check("timer frozen", held, {timer_count_high, timer_count_low});
        @(posedge clock);
        timer_ext_clocked <= 1'b1;
        toggle(1, 1);
        check("sleep ext capture", 16'h1, npulse[15:0]);
        check_value();
        reg_write(ccu_pkg::CCU_OFF_MASK, 8'h00);
        @(posedge clock);
        #1;
        check("irq masked", 16'h0, {15'h0, capture_irq});
        conclude();
    end
endmodule
